// ==== core/gmx_ctrl.v ====
`timescale 1ns/1ns
`default_nettype none
`include "gmx_map.vh"
// Summary of operation
// - Writing one to pin-group bit 3 resets the whole device logic.
// - Reset bit is never stored by the write; reads return zero.
// - Bit 2 selects pins 3..0 as GPIO or channel B modem lines.
// - Bit 1 selects pins 7..4 as GPIO or channel A modem lines.
// - Latch off: pin returning to original level withdraws pending interrupt.
// - Latch on: interrupt stays, pin-state bit holds causing level until read.
// - Extra-features register reachable only when select bit 2 is zero; resets zero.
// - Infrared bit 7 clear gives three-sixteenths pulses, up to 115.2 Kbps.
// - Infrared bit 7 set gives quarter-bit pulses, up to 1.152 Mbps.
// - Bit 4 lets transmitter drive request-to-send as direction output.
// - Polarity clear: low transmitting, high receiving; ignored when disabled.
// - Polarity set: high transmitting, low receiving.
// - Control registers shared by all channels; soft reset resets every channel.
// - Pin-state read returns pin levels; write drives output pins.
module gmx_ctrl
#(
  parameter NUM_CH = 1,
  parameter SRST_CYCLES = `GMX_SRST_CYCLES
)
(
  // Clock and reset
  input wire core_clk,
  input wire rstn,
  // Host register port
  input wire reg_wr,
  input wire reg_rd,
  input wire [`GMX_ADDR_W-1:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  // Special function select, bit 2 banks registers
  input wire [7:0] special_function_select,
  // GPIO pins
  input wire [7:0] gpio_in,
  input wire [7:0] gpio_dir,
  output reg [7:0] gpio_out,
  output reg [7:0] gpio_oe,
  output reg gpio_irq,
  // Modem lines
  input wire ring_indicate_a,
  input wire carrier_detect_a,
  input wire terminal_ready_a,
  input wire set_ready_a,
  input wire ring_indicate_b,
  input wire carrier_detect_b,
  input wire terminal_ready_b,
  input wire set_ready_b,
  output reg [7:0] modem_in,
  // Transmitter status and direction output
  input wire tx_busy,
  input wire uart_rts,
  output reg rts_pin,
  // Infrared encoder
  input wire ir_tick16,
  input wire ir_bit_start,
  input wire ir_bit_zero,
  output reg ir_tx,
  // Reset to all channels
  output reg [NUM_CH-1:0] chan_soft_rst
);
  // ************************
  // Registers
  // ************************
  reg [7:0] pin_group_and_reset_control;
  reg [7:0] extra_features_control;
  reg [7:0] pin_interrupt_enable;
  reg [7:0] pin_state_register;
  reg [7:0] pin_ref;
  reg [7:0] pin_pend;
  reg [7:0] srst_cnt;
  reg soft_rst;
  wire ir_pulse;
  wire ef_bank;
  wire [7:0] modem_mask;
  wire [7:0] next_pend;
  wire [7:0] pin_changed;
  wire wr_pin_state;
  wire rd_pin_state;

  assign ef_bank = ~special_function_select[`GMX_SFS_BANK];
  assign modem_mask = {{4{pin_group_and_reset_control[`GMX_PG_HIGH_MODEM]}},
                       {4{pin_group_and_reset_control[`GMX_PG_LOW_MODEM]}}};
  assign wr_pin_state = reg_wr && reg_addr == `GMX_OFF_PIN_STATE;
  assign rd_pin_state = reg_rd && reg_addr == `GMX_OFF_PIN_STATE;
  assign pin_changed = (gpio_in ^ pin_ref) & ~gpio_dir & ~modem_mask & pin_interrupt_enable;
  // Latch off drops pending when pin returns; latch on keeps until read
  assign next_pend = pin_group_and_reset_control[`GMX_PG_LATCH] ?
                     ((pin_pend | pin_changed) & ~modem_mask) : pin_changed;

  // ************************
  // Soft reset sequencer
  // ************************
  // A few cycles are held so every channel sees the reset
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      srst_cnt <= 8'h_00;
      soft_rst <= 1'b0;
      chan_soft_rst <= {NUM_CH{1'b0}};
    end
    else if (reg_wr && reg_addr == `GMX_OFF_PIN_GROUP && reg_wdata[`GMX_PG_SOFT_RESET])
    begin
      srst_cnt <= SRST_CYCLES[7:0];
      soft_rst <= 1'b1;
      chan_soft_rst <= {NUM_CH{1'b1}};
    end
    else if (srst_cnt > 8'h_01)
    begin
      srst_cnt <= srst_cnt - 8'h_01;
    end
    else
    begin
      srst_cnt <= 8'h_00;
      soft_rst <= 1'b0;
      chan_soft_rst <= {NUM_CH{1'b0}};
    end
  end

  // ************************
  // Control registers
  // ************************
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pin_group_and_reset_control <= `GMX_PG_RESET;
      extra_features_control <= `GMX_EF_RESET;
      pin_interrupt_enable <= `GMX_IRQ_EN_RESET;
      pin_state_register <= `GMX_PIN_OUT_RESET;
    end
    else if (soft_rst)
    begin
      // Soft reset bit reads back zero from here on
      pin_group_and_reset_control <= `GMX_PG_RESET;
      extra_features_control <= `GMX_EF_RESET;
      pin_interrupt_enable <= `GMX_IRQ_EN_RESET;
      pin_state_register <= `GMX_PIN_OUT_RESET;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `GMX_OFF_PIN_GROUP:
          pin_group_and_reset_control <= reg_wdata & `GMX_PG_WMASK & ~(8'h_01 << `GMX_PG_SOFT_RESET);
        `GMX_OFF_EXTRA:
          if (ef_bank)
            extra_features_control <= reg_wdata & `GMX_EF_WMASK;
        `GMX_OFF_PIN_IRQ_EN:
          pin_interrupt_enable <= reg_wdata;
        `GMX_OFF_PIN_STATE:
          pin_state_register <= reg_wdata;
        default:
          pin_state_register <= pin_state_register;
      endcase
    end
  end

  // ************************
  // Pin change tracking
  // ************************
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pin_ref <= 8'h_00;
      pin_pend <= 8'h_00;
      gpio_irq <= 1'b0;
    end
    else if (soft_rst)
    begin
      pin_ref <= gpio_in;
      pin_pend <= 8'h_00;
      gpio_irq <= 1'b0;
    end
    else if (rd_pin_state)
    begin
      // Read takes the current pin level as the new reference, even for latched bits
      pin_ref <= gpio_in;
      pin_pend <= 8'h_00;
      gpio_irq <= 1'b0;
    end
    else
    begin
      pin_pend <= next_pend;
      gpio_irq <= |next_pend;
    end
  end

  // ************************
  // Pins, readback and outputs
  // ************************
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      gpio_out <= `GMX_PIN_OUT_RESET;
      gpio_oe <= 8'h_00;
      modem_in <= 8'h_00;
      rts_pin <= 1'b1;
      reg_rdata <= 8'h_00;
    end
    else
    begin
      gpio_out <= wr_pin_state ? reg_wdata : pin_state_register;
      gpio_oe <= gpio_dir & ~modem_mask;
      // Modem lines: ring, carrier, terminal ready, set ready per group
      modem_in <= {ring_indicate_a, carrier_detect_a, terminal_ready_a, set_ready_a,
                   ring_indicate_b, carrier_detect_b, terminal_ready_b, set_ready_b} & modem_mask;
      if (extra_features_control[`GMX_EF_DIR_EN])
        rts_pin <= tx_busy ~^ extra_features_control[`GMX_EF_DIR_POL];
      else
        rts_pin <= uart_rts;
      reg_rdata <= 8'h_00;
      if (reg_rd)
      begin
        case (reg_addr)
          `GMX_OFF_PIN_GROUP:
            reg_rdata <= pin_group_and_reset_control & `GMX_PG_WMASK;
          `GMX_OFF_EXTRA:
            reg_rdata <= ef_bank ? extra_features_control : 8'h_00;
          `GMX_OFF_PIN_IRQ_EN:
            reg_rdata <= pin_interrupt_enable;
          `GMX_OFF_PIN_STATE:
            // Latched bits hold the level that raised the interrupt
            reg_rdata <= (gpio_in & ~(pin_pend & {8{pin_group_and_reset_control[`GMX_PG_LATCH]}}))
                         | (~pin_ref & pin_pend & {8{pin_group_and_reset_control[`GMX_PG_LATCH]}});
          default:
            reg_rdata <= 8'h_00;
        endcase
      end
    end
  end

  // ************************
  // Infrared encoder
  // ************************
  gmx_ir_pulse u_ir
  (
    .core_clk(core_clk),
    .rstn(rstn),
    .soft_rst(soft_rst),
    .fast_mode(extra_features_control[`GMX_EF_IR_FAST]),
    .tick16(ir_tick16),
    .bit_start(ir_bit_start),
    .bit_is_zero(ir_bit_zero),
    .ir_pulse(ir_pulse)
  );

  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      ir_tx <= 1'b0;
    else
      ir_tx <= ir_pulse;
  end
endmodule
`default_nettype wire

// ==== core/gmx_ir_pulse.v ====
`timescale 1ns/1ns
`default_nettype none
// ************************
// Infrared pulse shaper, counts 16ths of a bit
// ************************
module gmx_ir_pulse
(
  // Clock and reset
  input wire core_clk,
  input wire rstn,
  input wire soft_rst,
  // Control
  input wire fast_mode,
  input wire tick16,
  input wire bit_start,
  input wire bit_is_zero,
  // Output
  output reg ir_pulse
);
  reg [3:0] phase;
  reg active;
  wire [3:0] width;
  assign width = fast_mode ? 4'h_4 : 4'h_3;
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      phase <= 4'h_0;
      active <= 1'b0;
      ir_pulse <= 1'b0;
    end
    else if (soft_rst)
    begin
      phase <= 4'h_0;
      active <= 1'b0;
      ir_pulse <= 1'b0;
    end
    else if (bit_start)
    begin
      phase <= 4'h_0;
      active <= bit_is_zero;
      ir_pulse <= bit_is_zero;
    end
    else if (tick16 && active)
    begin
      phase <= phase + 4'h_1;
      // Pulse ends after width sixteenths
      if (phase + 4'h_1 >= width)
      begin
        active <= 1'b0;
        ir_pulse <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ==== core/gmx_map.vh ====
`ifndef GMX_MAP_VH
`define GMX_MAP_VH
// ************************
// Register offsets
// ************************
`define GMX_ADDR_W 4
`define GMX_OFF_PIN_STATE 4'h_b
`define GMX_OFF_PIN_IRQ_EN 4'h_c
`define GMX_OFF_PIN_GROUP 4'h_e
`define GMX_OFF_EXTRA 4'h_f
// ************************
// Field positions
// ************************
`define GMX_PG_SOFT_RESET 3
`define GMX_PG_LOW_MODEM 2
`define GMX_PG_HIGH_MODEM 1
`define GMX_PG_LATCH 0
`define GMX_PG_WMASK 8'h_0f
`define GMX_EF_IR_FAST 7
`define GMX_EF_DIR_POL 5
`define GMX_EF_DIR_EN 4
`define GMX_EF_WMASK 8'h_b0
`define GMX_SFS_BANK 2
// ************************
// Reset values
// ************************
`define GMX_PG_RESET 8'h_00
`define GMX_EF_RESET 8'h_00
`define GMX_PIN_OUT_RESET 8'h_ff
`define GMX_IRQ_EN_RESET 8'h_00
// ************************
// Timing
// ************************
`define GMX_CLK_NS 4
`define GMX_SRST_NS 16
`define GMX_SRST_CYCLES ((`GMX_SRST_NS + `GMX_CLK_NS - 1) / `GMX_CLK_NS)
`endif

// ==== tb/gmx_ctrl_assertions.sv ====
`timescale 1ns/1ns
`default_nettype none
// ****
// Checker
// ****
module gmx_chk #(parameter NUM_CH = 1, parameter SRST_CYCLES = 4)
(
  // Clock and reset
  input wire core_clk,
  input wire rstn,
  // Host port
  input wire reg_wr,
  input wire reg_rd,
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  input wire [7:0] special_function_select,
  // Pins
  input wire [7:0] gpio_dir,
  input wire [7:0] gpio_oe,
  input wire tx_busy,
  input wire uart_rts,
  input wire rts_pin,
  input wire [NUM_CH-1:0] chan_soft_rst
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  wire s = chan_soft_rst[0];
  wire sw = reg_wr && reg_addr == 4'h_e && !s && reg_wdata[3];
  wire rf = reg_rd && reg_addr == 4'h_f;
  reg [7:0] ef;
  reg [2:0] pg;
  reg [7:0] n;
  wire en = ef[4];
  wire pol = ef[5];
  wire [7:0] oe = gpio_dir & ~{{4{pg[1]}}, {4{pg[2]}}};
  // Shadow copies let the pin checks run from the ports alone
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ef <= 8'h_00;
      pg <= 3'h_0;
      n <= 8'h_00;
    end
    else
    begin
      n <= s ? n + 8'h_01 : 8'h_00;
      if (s || sw)
        pg <= 3'h_0;
      else if (reg_wr && reg_addr == 4'h_e)
        pg <= reg_wdata[2:0];
      if (s)
        ef <= 8'h_00;
      else if (reg_wr && reg_addr == 4'h_f && !special_function_select[2])
        ef <= reg_wdata & 8'h_b0;
    end
  end
  chk_srst_start: assert property (sw |=> s)
    else $error("soft reset not started");
  chk_srst_len: assert property ($fell(s) |-> n == SRST_CYCLES)
    else $error("soft reset length");
  chk_srst_all: assert property (chan_soft_rst == {NUM_CH{s}})
    else $error("channels reset apart");
  chk_ef_hidden: assert property (rf && special_function_select[2] |=> reg_rdata == 8'h_00)
    else $error("hidden register read");
  chk_pg_resvd: assert property (reg_rd && reg_addr == 4'h_e |=> reg_rdata[7:3] == 5'h_00)
    else $error("pin group upper bits");
  chk_ef_resvd: assert property (rf |=> (reg_rdata & 8'h_4f) == 8'h_00)
    else $error("extra reserved bits");
  chk_dir_drive: assert property ($past(rstn) && !$past(s) && $past(en) |-> rts_pin == ($past(tx_busy) ~^ $past(pol)))
    else $error("direction output");
  chk_dir_off: assert property ($past(rstn) && !$past(s) && !$past(en) |-> rts_pin == $past(uart_rts))
    else $error("rts not passed through");
  chk_oe_group: assert property ($past(rstn) && !$past(s) |-> gpio_oe == $past(oe))
    else $error("pin enable vs group");
endmodule
bind gmx_ctrl gmx_chk #(.NUM_CH(NUM_CH), .SRST_CYCLES(SRST_CYCLES)) i_chk (.core_clk, .rstn, .reg_wr, .reg_rd,
  .reg_addr, .reg_wdata, .reg_rdata, .special_function_select, .gpio_dir, .gpio_oe, .tx_busy, .uart_rts,
  .rts_pin, .chan_soft_rst);
`default_nettype wire

// ==== tb/gmx_host.sv ====
`timescale 1ns/1ns
`default_nettype none
// ****
// Host side of the register port
// ****
module gmx_host
(
  // Clock
  input wire core_clk,
  // Register port
  output logic reg_wr,
  output logic reg_rd,
  output logic [3:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire [7:0] reg_rdata
);
  initial
  begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h_0;
    reg_wdata = 8'h_00;
  end
  // One-cycle strobe; the next call waits an edge, so pulses never merge
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask
endmodule
`default_nettype wire

// ==== tb/tb_gpio_modem_extra_feature_ctrl.sv ====
`timescale 1ns/1ns
`default_nettype none
// ****
// Bench
// ****
module tb_gpio_modem_extra_feature_ctrl;
  logic core_clk, rstn, tx_busy, uart_rts, tick, bstart, bzero;
  logic [7:0] sfs, gpio_in, gpio_dir, mdm, d, n;
  logic [1:0] tc;
  wire reg_wr, reg_rd, gpio_irq, rts_pin, ir_tx;
  wire [3:0] reg_addr;
  wire [7:0] reg_wdata, reg_rdata, gpio_out, gpio_oe, modem_in;
  wire [0:0] chan_soft_rst;
  int mismatches, checked;
  gmx_host i_host (.core_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata);
  gmx_ctrl #(.NUM_CH(1), .SRST_CYCLES(4)) i_dut (.core_clk, .rstn, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .special_function_select(sfs), .gpio_in, .gpio_dir, .gpio_out, .gpio_oe, .gpio_irq,
    .ring_indicate_a(mdm[7]), .carrier_detect_a(mdm[6]), .terminal_ready_a(mdm[5]), .set_ready_a(mdm[4]),
    .ring_indicate_b(mdm[3]), .carrier_detect_b(mdm[2]), .terminal_ready_b(mdm[1]), .set_ready_b(mdm[0]),
    .modem_in, .tx_busy, .uart_rts, .rts_pin, .ir_tick16(tick), .ir_bit_start(bstart), .ir_bit_zero(bzero),
    .ir_tx, .chan_soft_rst);
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // Infrared sixteenth-bit tick every 4 cycles
  always @(posedge core_clk)
  begin
    tc <= tc + 2'h_1;
    tick <= tc == 2'h_3;
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic st;
    repeat (3) @(posedge core_clk);
    #1;
  endtask
  task automatic end_of_test;
    if (mismatches == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic t_regs;
    i_host.rd(4'h_e, d);
    chk("pg reset", 8'h_00, d);
    i_host.wr(4'h_f, 8'h_ff);
    i_host.rd(4'h_f, d);
    chk("ef mask", 8'h_b0, d);
    i_host.wr(4'h_e, 8'h_f7);
    i_host.rd(4'h_e, d);
    chk("pg mask", 8'h_07, d);
    @(posedge core_clk) sfs <= 8'h_04;
    i_host.rd(4'h_f, d);
    chk("ef hidden", 8'h_00, d);
    i_host.wr(4'h_f, 8'h_00);
    @(posedge core_clk) sfs <= 8'h_00;
    i_host.rd(4'h_f, d);
    chk("ef kept", 8'h_b0, d);
  endtask
  // Modem read polarity is left open, so only the toggle is compared
  task automatic t_groups;
    // Pins must be outputs, or the enable never shows the group mask
    @(posedge core_clk) gpio_dir <= 8'h_ff;
    for (int i = 0; i < 4; i++)
    begin
      i_host.wr(4'h_e, {5'h_00, i[1:0], 1'b0});
      @(posedge core_clk) mdm <= 8'h_ff;
      st;
      chk("oe", {{4{!i[0]}}, {4{!i[1]}}}, gpio_oe);
      d = modem_in;
      @(posedge core_clk) mdm <= 8'h_00;
      st;
      chk("modem", {{4{i[0]}}, {4{i[1]}}}, d ^ modem_in);
    end
  endtask
  task automatic t_rs485;
    for (int p = 0; p < 2; p++)
    begin
      i_host.wr(4'h_f, {2'h_0, p[0], 5'h_10});
      @(posedge core_clk) tx_busy <= 1'b1;
      st;
      chk("rts tx", {7'h_00, p[0]}, {7'h_00, rts_pin});
      @(posedge core_clk) tx_busy <= 1'b0;
      st;
      chk("rts rx", {7'h_00, !p[0]}, {7'h_00, rts_pin});
    end
    i_host.wr(4'h_f, 8'h_20);
    @(posedge core_clk) uart_rts <= 1'b0;
    st;
    chk("rts off", 8'h_00, {7'h_00, rts_pin});
    @(posedge core_clk) tx_busy <= 1'b1;
    st;
    chk("rts off busy", 8'h_00, {7'h_00, rts_pin});
  endtask
  task automatic t_srst;
    i_host.wr(4'h_e, 8'h_08);
    n = 8'h_00;
    for (int k = 0; k < 10; k++)
    begin
      #1;
      if (chan_soft_rst === 1'b1)
        n++;
      @(posedge core_clk);
    end
    chk("srst len", 8'h_04, n);
    i_host.rd(4'h_e, d);
    chk("srst bit", 8'h_00, d);
    i_host.rd(4'h_f, d);
    chk("ef after srst", 8'h_00, d);
  endtask
  task automatic t_pins;
    @(posedge core_clk) gpio_dir <= 8'h_ff;
    i_host.wr(4'h_b, 8'h_5a);
    st;
    chk("pin out", 8'h_5a, gpio_out);
    @(posedge core_clk) gpio_dir <= 8'h_00;
    st;
    i_host.rd(4'h_b, d);
    chk("pin in", 8'h_a5, d);
  endtask
  // Pin interrupt with input latching off, then on
  task automatic t_irq;
    i_host.wr(4'h_c, 8'h_ff);
    i_host.rd(4'h_b, d);
    chk("pin ref", 8'h_a5, d);
    for (int l = 0; l < 2; l++)
    begin
      i_host.wr(4'h_e, {7'h_00, l[0]});
      @(posedge core_clk) gpio_in <= 8'h_a4;
      st;
      chk("irq set", 8'h_01, {7'h_00, gpio_irq});
      @(posedge core_clk) gpio_in <= 8'h_a5;
      st;
      chk("irq after return", {7'h_00, l[0]}, {7'h_00, gpio_irq});
    end
    i_host.rd(4'h_b, d);
    chk("latched level", 8'h_a4, d);
    st;
    chk("irq after read", 8'h_00, {7'h_00, gpio_irq});
  endtask
  // Width in cycles: three or four sixteenths, each a tick of 4 cycles
  task automatic t_ir;
    for (int p = 0; p < 2; p++)
    begin
      i_host.wr(4'h_f, {p[0], 7'h_00});
      // Start the bit together with a tick so the pulse spans whole ticks
      @(posedge core_clk);
      while (tc != 2'h_3)
        @(posedge core_clk);
      bstart <= 1'b1;
      @(posedge core_clk) bstart <= 1'b0;
      n = 8'h_00;
      repeat (100)
      begin
        @(posedge core_clk);
        #1;
        if (ir_tx === 1'b1)
          n++;
      end
      chk("ir width", p ? 8'h_10 : 8'h_0c, n);
    end
  endtask
  initial
  begin
    {rstn, tx_busy, bstart, tick, tc} = 6'h_00;
    {uart_rts, bzero} = 2'h_3;
    {sfs, gpio_dir, mdm} = 24'h_0000_00;
    gpio_in = 8'h_a5;
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    t_regs;
    t_groups;
    t_rs485;
    t_srst;
    t_pins;
    t_irq;
    t_ir;
    end_of_test;
  end
  initial
  begin
    #20000;
    mismatches++;
    end_of_test;
  end
endmodule
`default_nettype wire
